//--- design/tpg_pkg.sv
`default_nettype none
package tpg_pkg;

  // Port geometry
  localparam int unsigned PORT_W = 8;
  localparam int unsigned PORT_N = 3;

  // Data-space locations of the six port registers
  localparam logic [7:0] ADDR_A_LATCH = 8'hc0;
  localparam logic [7:0] ADDR_B_LATCH = 8'hc1;
  localparam logic [7:0] ADDR_C_LATCH = 8'hc2;
  localparam logic [7:0] ADDR_A_DIR   = 8'hc4;
  localparam logic [7:0] ADDR_B_DIR   = 8'hc5;
  localparam logic [7:0] ADDR_C_DIR   = 8'hc6;

  // Reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_A_RST = 8'h00;
  localparam logic [7:0] DIR_B_RST = 8'h00;
  localparam logic [7:0] DIR_C_RST = 8'h04;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [2:0][7:0] DIR_RST = {DIR_C_RST, DIR_B_RST, DIR_A_RST};

  // Special line positions
  localparam int unsigned POWER_BIT = 2;
  localparam int unsigned VSYNC_BIT = 2;
  localparam int unsigned HSYNC_BIT = 3;
  localparam int unsigned SCL_BIT   = 5;
  localparam int unsigned SDA_BIT   = 6;
  localparam int unsigned SEN_BIT   = 7;
  localparam int unsigned BLANK_BIT = 3;
  localparam int unsigned RED_BIT   = 5;
  localparam int unsigned GREEN_BIT = 6;
  localparam int unsigned BLUE_BIT  = 7;

  // Fixed output stage per line: 1 = open-drain, 0 = push-pull
  localparam logic [7:0] OD_A = 8'hff;
  localparam logic [7:0] OD_B = 8'he0;
  localparam logic [7:0] OD_C = 8'he8;
  localparam logic [2:0][7:0] OD_MASK = {OD_C, OD_B, OD_A};

  // Lines that own a pull-up resistor
  localparam logic [7:0] PU_A = 8'h00;
  localparam logic [7:0] PU_B = 8'hff;
  localparam logic [7:0] PU_C = 8'hff;
  localparam logic [2:0][7:0] PU_MASK = {PU_C, PU_B, PU_A};

  // Register select, one-hot
  typedef enum logic [6:0] {
    SEL_NONE = 7'b0000001,
    SEL_LA   = 7'b0000010,
    SEL_LB   = 7'b0000100,
    SEL_LC   = 7'b0001000,
    SEL_DA   = 7'b0010000,
    SEL_DB   = 7'b0100000,
    SEL_DC   = 7'b1000000
  } tpg_sel_t;

  // Pad drive bundle of one port
  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] oe;
    logic [7:0] pu;
  } tpg_pad_t;

  // Data-space access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpg_bus_t;

endpackage
`default_nettype wire

//--- design/tpg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_sync (
  input  wire logic       ref_clk,  // Core clock
  input  wire logic       arst_n,   // Async reset, active low
  input  wire logic       ce,       // Clock enable
  input  wire logic [7:0] d,        // Raw pin levels
  output logic      [7:0] q         // Synchronised levels
);

  logic [7:0] meta_r;
  logic [7:0] meta_nxt;
  logic [7:0] q_nxt;

  // First stage feeds only the second stage
  always_comb begin
    meta_nxt = ce ? d : meta_r;
    q_nxt    = ce ? meta_r : q;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 8'h00;
      q      <= 8'h00;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule
`default_nettype wire

//--- design/tpg_pad.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_pad #(
  parameter logic [7:0] OD_MASK = 8'h00,  // Open-drain lines
  parameter logic [7:0] PU_MASK = 8'hff,  // Lines with pull-up
  parameter logic [7:0] RST_OE  = 8'h00   // Direction after reset
) (
  input  wire logic              ref_clk,  // Core clock
  input  wire logic              arst_n,   // Async reset, active low
  input  wire logic              ce,       // Clock enable
  input  wire logic [7:0]        latch,    // Level/latch bits
  input  wire logic [7:0]        dir,      // Direction bits
  input  wire logic [7:0]        alt,      // Peripheral outputs, 1 if none
  output var tpg_pkg::tpg_pad_t  pad       // Registered pad controls
);

  tpg_pkg::tpg_pad_t pad_nxt;
  logic [7:0]        eff;

  // Output value is the latch gated by the shared peripheral signal
  always_comb begin
    eff         = latch & alt;
    pad_nxt     = pad;
    if (ce) begin
      // Open-drain lines only pull low, push-pull lines follow eff
      // latch value driven
      pad_nxt.drv = eff & ~OD_MASK;
      pad_nxt.oe  = dir & (~OD_MASK | ~eff);
      // Pull-up only on input lines with latch 0 and a resistor
      // latch selects pull-up
      pad_nxt.pu  = ~dir & ~latch & PU_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pad.drv <= 8'h00;
      pad.oe  <= RST_OE;
      pad.pu  <= PU_MASK & ~RST_OE;
    end else begin
      pad <= pad_nxt;
    end
  end

endmodule
`default_nettype wire

//--- design/tpg_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio (
  input  wire logic       ref_clk,            // Core clock, 20 MHz
  input  wire logic       arst_n,             // Async reset, active low
  input  wire logic       ce,                 // Clock enable, freezes all
  input  wire logic [7:0] bus_addr,           // Data-space address
  input  wire logic [7:0] bus_wdata,          // Write data
  input  wire logic       bus_wr,             // Write strobe
  input  wire logic       bus_rd,             // Read strobe
  output logic      [7:0] bus_rdata,          // Read data, registered
  input  wire logic [7:0] port_a_lines_in,    // Port A pin levels
  output logic      [7:0] port_a_lines_out,   // Port A drive value
  output logic      [7:0] port_a_lines_oe,    // Port A output enable
  output logic      [7:0] port_a_lines_pu,    // Port A pull-up enable
  input  wire logic [7:0] port_b_lines_in,    // Port B pin levels
  output logic      [7:0] port_b_lines_out,   // Port B drive value
  output logic      [7:0] port_b_lines_oe,    // Port B output enable
  output logic      [7:0] port_b_lines_pu,    // Port B pull-up enable
  input  wire logic [7:0] port_c_lines_in,    // Port C pin levels
  output logic      [7:0] port_c_lines_out,   // Port C drive value
  output logic      [7:0] port_c_lines_oe,    // Port C output enable
  output logic      [7:0] port_c_lines_pu,    // Port C pull-up enable
  input  wire logic       serial_clock_out,   // Serial clock from SPI
  input  wire logic       serial_data_out,    // Serial data from SPI
  input  wire logic       serial_enable_out,  // Serial enable from SPI
  input  wire logic       osd_blank,          // Display blanking
  input  wire logic       osd_red,            // Display red
  input  wire logic       osd_green,          // Display green
  input  wire logic       osd_blue,           // Display blue
  output logic            vsync_to_osd,       // Vertical sync from B2
  output logic            hsync_to_osd        // Horizontal sync from B3
);

  tpg_pkg::tpg_bus_t  req;
  tpg_pkg::tpg_sel_t  wr_sel;
  tpg_pkg::tpg_sel_t  rd_sel;
  tpg_pkg::tpg_pad_t  pad [3];

  logic [2:0][7:0] latch_r;
  logic [2:0][7:0] latch_nxt;
  logic [2:0][7:0] dir_r;
  logic [2:0][7:0] dir_nxt;
  logic [2:0][7:0] pin_raw;
  logic [2:0][7:0] pin_sync;
  logic [2:0][7:0] alt;
  logic [2:0][7:0] rd_view;
  logic [7:0]      rdata_nxt;
  logic            vsync_nxt;
  logic            hsync_nxt;

  // Address decode, shared by the write and the read path
  function automatic tpg_pkg::tpg_sel_t reg_decode(input logic [7:0] a);
    tpg_pkg::tpg_sel_t s;
    s = tpg_pkg::SEL_NONE;
    if (a == tpg_pkg::ADDR_A_LATCH) s = tpg_pkg::SEL_LA;
    if (a == tpg_pkg::ADDR_B_LATCH) s = tpg_pkg::SEL_LB;
    if (a == tpg_pkg::ADDR_C_LATCH) s = tpg_pkg::SEL_LC;
    if (a == tpg_pkg::ADDR_A_DIR)   s = tpg_pkg::SEL_DA;
    if (a == tpg_pkg::ADDR_B_DIR)   s = tpg_pkg::SEL_DB;
    if (a == tpg_pkg::ADDR_C_DIR)   s = tpg_pkg::SEL_DC;
    return s;
  endfunction

  // Bundle the request and decode it
  always_comb begin
    req.wr    = bus_wr;
    req.rd    = bus_rd;
    req.addr  = bus_addr;
    req.wdata = bus_wdata;
    wr_sel    = reg_decode(req.addr);
    rd_sel    = reg_decode(req.addr);
  end

  assign pin_raw[0] = port_a_lines_in;
  assign pin_raw[1] = port_b_lines_in;
  assign pin_raw[2] = port_c_lines_in;

  // alternate routing. Lines without a peripheral see a constant 1.
  always_comb begin
    alt    = {3{8'hff}};
    alt[1][tpg_pkg::SCL_BIT]   = serial_clock_out;
    alt[1][tpg_pkg::SDA_BIT]   = serial_data_out;
    alt[1][tpg_pkg::SEN_BIT]   = serial_enable_out;
    alt[2][tpg_pkg::BLANK_BIT] = osd_blank;
    alt[2][tpg_pkg::RED_BIT]   = osd_red;
    alt[2][tpg_pkg::GREEN_BIT] = osd_green;
    alt[2][tpg_pkg::BLUE_BIT]  = osd_blue;
  end

  // three independent ports
  // One synchroniser and one pad stage per port
  for (genvar i = 0; i < 3; i++) begin : g_port
    tpg_sync u_sync (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .d       (pin_raw[i]),
      .q       (pin_sync[i])
    );

    tpg_pad #(
      .OD_MASK (tpg_pkg::OD_MASK[i]),
      .PU_MASK (tpg_pkg::PU_MASK[i]),
      .RST_OE  (tpg_pkg::DIR_RST[i])
    ) u_pad (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .latch   (latch_r[i]),
      .dir     (dir_r[i]),
      .alt     (alt[i]),
      .pad     (pad[i])
    );

    // inputs read the pin, outputs read the latch
    assign rd_view[i] = (dir_r[i] & latch_r[i]) | (~dir_r[i] & pin_sync[i]);
  end

  always_comb begin
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    if (ce && req.wr) begin
      case (wr_sel)
        tpg_pkg::SEL_LA: latch_nxt[0] = req.wdata;
        tpg_pkg::SEL_LB: latch_nxt[1] = req.wdata;
        tpg_pkg::SEL_LC: latch_nxt[2] = req.wdata;
        tpg_pkg::SEL_DA: dir_nxt[0]   = req.wdata;
        tpg_pkg::SEL_DB: dir_nxt[1]   = req.wdata;
        tpg_pkg::SEL_DC: dir_nxt[2]   = req.wdata;
        default: ;
      endcase
    end
  end

  // power switch line comes up as low output
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= {3{tpg_pkg::LATCH_RST}};
      dir_r   <= tpg_pkg::DIR_RST;
    end else begin
      latch_r <= latch_nxt;
      dir_r   <= dir_nxt;
    end
  end

  // read path. Unmapped reads answer zero; data holds till next read
  always_comb begin
    rdata_nxt = bus_rdata;
    if (ce && req.rd) begin
      case (rd_sel)
        tpg_pkg::SEL_LA: rdata_nxt = rd_view[0];
        tpg_pkg::SEL_LB: rdata_nxt = rd_view[1];
        tpg_pkg::SEL_LC: rdata_nxt = rd_view[2];
        tpg_pkg::SEL_DA: rdata_nxt = dir_r[0];
        tpg_pkg::SEL_DB: rdata_nxt = dir_r[1];
        tpg_pkg::SEL_DC: rdata_nxt = dir_r[2];
        default:         rdata_nxt = tpg_pkg::RDATA_RST;
      endcase
    end
  end

  // Sync levels for the display; only meaningful while B2/B3 are inputs
  always_comb begin
    vsync_nxt = ce ? pin_sync[1][tpg_pkg::VSYNC_BIT] : vsync_to_osd;
    hsync_nxt = ce ? pin_sync[1][tpg_pkg::HSYNC_BIT] : hsync_to_osd;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata    <= tpg_pkg::RDATA_RST;
      vsync_to_osd <= 1'b0;
      hsync_to_osd <= 1'b0;
    end else begin
      bus_rdata    <= rdata_nxt;
      vsync_to_osd <= vsync_nxt;
      hsync_to_osd <= hsync_nxt;
    end
  end

  // Pad controls leave straight from the pad stage flops
  assign port_a_lines_out = pad[0].drv;
  assign port_a_lines_oe  = pad[0].oe;
  assign port_a_lines_pu  = pad[0].pu;
  assign port_b_lines_out = pad[1].drv;
  assign port_b_lines_oe  = pad[1].oe;
  assign port_b_lines_pu  = pad[1].pu;
  assign port_c_lines_out = pad[2].drv;
  assign port_c_lines_oe  = pad[2].oe;
  assign port_c_lines_pu  = pad[2].pu;

  // Helper for the checks: set once any write has been taken
  logic seen_wr_r;
  logic seen_wr_nxt;

  always_comb begin
    seen_wr_nxt = seen_wr_r | (ce & req.wr);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_wr_r <= 1'b0;
    end else begin
      seen_wr_r <= seen_wr_nxt;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // Checks beside the logic they guard
  wr_latch_b_a: assert property (
    ce && bus_wr && bus_addr == tpg_pkg::ADDR_B_LATCH
      |=> latch_r[1] == $past(bus_wdata))
    else $error("port B latch write lost");

  rd_dir_b_a: assert property (
    ce && bus_rd && bus_addr == tpg_pkg::ADDR_B_DIR
      |=> bus_rdata == $past(dir_r[1]))
    else $error("port B direction read wrong");

  rd_pin_a: assert property (
    ce && bus_rd && bus_addr == tpg_pkg::ADDR_C_LATCH
      |=> bus_rdata == $past(rd_view[2]))
    else $error("port C latch read wrong");

  dir_oe_a: assert property (
    ce |=> port_b_lines_oe[4:0] == $past(dir_r[1][4:0]))
    else $error("push-pull enable not following direction");

  pull_up_a: assert property (
    ce |=> port_c_lines_pu == $past(~dir_r[2] & ~latch_r[2]))
    else $error("pull-up select wrong");

  push_drive_a: assert property (
    ce && dir_r[2][4] |=> port_c_lines_out[4] == $past(latch_r[2][4]))
    else $error("push-pull value not latch");

  port_a_od_a: assert property (
    port_a_lines_pu == 8'h00 && port_a_lines_out == 8'h00)
    else $error("port A drives high or pulls up");

  serial_and_a: assert property (
    ce |=> port_b_lines_oe[5] == $past(dir_r[1][5]
      & ~(latch_r[1][5] & serial_clock_out)))
    else $error("serial clock not ANDed with latch");

  od_release_a: assert property (
    ce && dir_r[2][3] && latch_r[2][3] && osd_blank
      |=> !port_c_lines_oe[3] ##0 !port_c_lines_out[3])
    else $error("open-drain line not released");

  reset_state_a: assert property (
    !seen_wr_r |-> dir_r == tpg_pkg::DIR_RST
      && latch_r == {3{tpg_pkg::LATCH_RST}}
      && port_c_lines_out[tpg_pkg::POWER_BIT] == 1'b0)
    else $error("reset state of port registers wrong");

  rd_unmapped_a: assert property (
    ce && bus_rd && reg_decode(bus_addr) == tpg_pkg::SEL_NONE
      |=> bus_rdata == tpg_pkg::RDATA_RST)
    else $error("unmapped read not zero");

  ce_freeze_a: assert property (
    !ce |=> $stable(latch_r) && $stable(dir_r) && $stable(bus_rdata))
    else $error("registers changed while clock enable low");

  // Main scenarios
  wr_b_c: cover property (ce && bus_wr
    && bus_addr == tpg_pkg::ADDR_B_LATCH);
  rd_input_c: cover property (ce && bus_rd
    && bus_addr == tpg_pkg::ADDR_A_LATCH && dir_r[0] == 8'h00);
  alt_out_c: cover property (dir_r[2][tpg_pkg::RED_BIT]
    && latch_r[2][tpg_pkg::RED_BIT] && osd_red);
  ce_low_c: cover property (!ce && bus_wr);

endmodule
`default_nettype wire

//--- dv/tpg_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_pins (
  input  wire logic              ref_clk,  // Core clock
  input  wire tpg_pkg::tpg_pad_t pad,      // Pad controls of one port
  input  wire logic [7:0]        ext,      // Level the board drives
  input  wire logic [7:0]        ext_en,   // Board drives the line
  output logic      [7:0]        pin       // Resolved pin level
);
  logic [7:0] flt_r = 8'h5a;  // Pattern for undriven, unpulled lines

  // Keeps changing, so a floating line never looks like a stable level
  always @(posedge ref_clk) begin
    flt_r <= ~flt_r;
  end

  // Line resolution: pad drive wins, then board, then pull-up
  // pull-up and open-drain
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) begin
        pin[i] = pad.drv[i];
      end else if (ext_en[i]) begin
        pin[i] = ext[i];
      end else if (pad.pu[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = flt_r[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/three_port_gpio_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module three_port_gpio_tb_top;
  localparam logic [7:0] LA[3] = '{tpg_pkg::ADDR_A_LATCH,
    tpg_pkg::ADDR_B_LATCH, tpg_pkg::ADDR_C_LATCH};
  localparam logic [7:0] DA[3] = '{tpg_pkg::ADDR_A_DIR,
    tpg_pkg::ADDR_B_DIR, tpg_pkg::ADDR_C_DIR};
  logic              ref_clk;
  logic              arst_n;
  logic              ce;
  logic              bus_wr;
  logic              bus_rd;
  logic [7:0]        bus_addr;
  logic [7:0]        bus_wdata;
  logic [7:0]        bus_rdata;
  logic [6:0]        alt_s;  // blue green red blank sen sda scl
  logic              vsync_to_osd;
  logic              hsync_to_osd;
  tpg_pkg::tpg_pad_t pd[3];
  logic [7:0]        pins[3];
  logic [7:0]        ext[3];
  logic [7:0]        ext_en[3];
  logic [7:0]        dir_m[3];
  logic [7:0]        lat_m[3];
  logic [31:0]       seed = 32'd55039;
  int                err_count = 0;
  int                checks = 0;

  // Clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  tpg_gpio u_tpg_gpio (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .port_a_lines_in(pins[0]), .port_a_lines_out(pd[0].drv),
    .port_a_lines_oe(pd[0].oe), .port_a_lines_pu(pd[0].pu),
    .port_b_lines_in(pins[1]), .port_b_lines_out(pd[1].drv),
    .port_b_lines_oe(pd[1].oe), .port_b_lines_pu(pd[1].pu),
    .port_c_lines_in(pins[2]), .port_c_lines_out(pd[2].drv),
    .port_c_lines_oe(pd[2].oe), .port_c_lines_pu(pd[2].pu),
    .serial_clock_out(alt_s[0]), .serial_data_out(alt_s[1]),
    .serial_enable_out(alt_s[2]), .osd_blank(alt_s[3]),
    .osd_red(alt_s[4]), .osd_green(alt_s[5]), .osd_blue(alt_s[6]),
    .vsync_to_osd(vsync_to_osd), .hsync_to_osd(hsync_to_osd));

  // One board model per port
  for (genvar g = 0; g < 3; g++) begin : g_pin
    tpg_pins u_tpg_pins (.ref_clk(ref_clk), .pad(pd[g]), .ext(ext[g]),
      .ext_en(ext_en[g]), .pin(pins[g]));
  end

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Peripheral value seen by each line, 1 where none is wired
  function automatic logic [7:0] alt_of(input int p);
    if (p == 1) return {alt_s[2:0], 5'h1f};
    if (p == 2) return {alt_s[6:4], 1'b1, alt_s[3], 3'h7};
    return 8'hff;
  endfunction

  // Expected pads; drv only where a push-pull line drives
  function automatic tpg_pkg::tpg_pad_t exp_pad(input int p,
      input logic [7:0] dr, input logic [7:0] la);
    tpg_pkg::tpg_pad_t e;
    logic [7:0] od;
    logic [7:0] v;
    od = tpg_pkg::OD_MASK[p];
    v = la & alt_of(p);
    e.oe = (dr & ~od) | (dr & od & ~v);
    e.drv = dr & ~od & v;
    e.pu = ~dr & ~la & tpg_pkg::PU_MASK[p];
    return e;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  // Strobe held over one taken edge, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    cyc(1);
    bus_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_addr = a;
    bus_rd = 1'b1;
    cyc(1);
    d = bus_rdata;
    bus_rd = 1'b0;
    cyc(1);
  endtask

  // Program a port; board drives every line that has no pull-up
  task automatic set_port(input int p, input logic [7:0] d,
      input logic [7:0] l);
    tpg_pkg::tpg_pad_t e;
    e = exp_pad(p, d, l);
    dir_m[p] = d;
    lat_m[p] = l;
    ext_en[p] = 8'(rnd()) | ~e.pu;
    wr(DA[p], d);
    wr(LA[p], l);
    cyc(4);
  endtask

  task automatic chk_port(input int p);
    tpg_pkg::tpg_pad_t e;
    logic [7:0] d;
    logic [7:0] pe;
    e = exp_pad(p, dir_m[p], lat_m[p]);
    pe = (ext_en[p] & ext[p]) | ~ext_en[p];
    chk(pd[p].oe, e.oe);
    chk(pd[p].pu, e.pu);
    chk(pd[p].drv & dir_m[p] & ~tpg_pkg::OD_MASK[p], e.drv);
    rd(LA[p], d);
    chk(d, (dir_m[p] & lat_m[p]) | (~dir_m[p] & pe));
    rd(DA[p], d);
    chk(d, dir_m[p]);
    if (p == 1 && dir_m[1][3:2] == 2'b00) begin
      chk({6'h00, hsync_to_osd, vsync_to_osd}, {6'h00, pe[3:2]});
    end
  endtask

  // Reset and model return to power-on state
  task automatic do_reset();
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    dir_m = '{8'h00, 8'h00, 8'h04};
    lat_m = '{8'h00, 8'h00, 8'h00};
    cyc(3);
    for (int p = 0; p < 3; p++) chk_port(p);
  endtask

  task automatic give_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: a bounded count of cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] d;
    int p;
    arst_n = 1'b0;
    ce = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    alt_s = 7'h7f;
    for (int i = 0; i < 3; i++) begin
      ext[i] = 8'(rnd());
      ext_en[i] = 8'hff;
    end
    #5;
    do_reset();
    // Random modes, levels and peripheral values on all ports
    for (int i = 0; i < 60; i++) begin
      p = int'(rnd() % 3);
      alt_s = 7'(rnd());
      ext[p] = 8'(rnd());
      set_port(p, 8'(rnd()), 8'(rnd()));
      chk_port(p);
    end
    // shared lines as outputs with latch one
    set_port(1, 8'he0, 8'he0);
    set_port(2, 8'he8, 8'he8);
    for (int i = 0; i < 12; i++) begin
      alt_s = 7'(rnd());
      cyc(2);
      chk_port(1 + i % 2);
    end
    // read-modify-write turns pin levels into latch bits
    set_port(1, 8'h0f, 8'h00);
    rd(LA[1], d);
    set_port(1, 8'h0f, d | 8'h01);
    chk_port(1);
    // Unbonded lines parked as outputs driving low
    set_port(0, 8'hff, 8'h00);
    chk_port(0);
    // Unmapped places read zero and ignore writes
    wr(8'hc3, 8'hff);
    wr(8'hc7, 8'hff);
    rd(8'hc3, d);
    chk(d, 8'h00);
    // Write strobe ignored while the clock enable is low
    ce = 1'b0;
    wr(DA[2], ~dir_m[2]);
    ce = 1'b1;
    cyc(4);
    for (int i = 0; i < 3; i++) chk_port(i);
    // Second reset in mid-run
    do_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
